// ---- rtl/dhrx_video_rx.sv ----
// Serial video link receiver with elastic crossing and vertical timing check
// Summary of operation
// - Lane bits are captured on both rising and falling forwarded clock edges.
// - One clock period holds two bits, one per half cycle.
// - An elastic FIFO absorbs bit-rate variation between link and core clocks.
// - First burst bit is taken on a rising edge, then edges alternate.
// - A frame has 1280 active lines in at least 1286 total lines.
`include "dhrx_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dhrx_video_rx
(
   // Core clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Forwarded link clock and lanes
   input wire logic hs_clk,
   input wire logic hs_burst,
   input wire logic [`DHRX_LANES-1:0] lane_data,
   // Line markers from the packet layer
   input wire logic line_start,
   input wire logic line_is_sync,
   input wire logic line_is_active,
   // Pixel output
   output logic [`DHRX_WORD_W-1:0] px_data,
   output logic px_valid,
   // Frame status
   output logic frame_ok,
   output logic frame_bad,
   output logic timing_gate
);

   function automatic logic at_least(input logic [`DHRX_LINE_W-1:0] cnt,
                                     input logic [`DHRX_LINE_W-1:0] lim);
      at_least = (cnt >= lim);
   endfunction

   function automatic logic [`DHRX_LINE_W-1:0] sat_inc(
      input logic [`DHRX_LINE_W-1:0] cnt);
      sat_inc = (&cnt) ? cnt : cnt + 11'h001;
   endfunction

   function automatic logic [`DHRX_FIFO_AW:0] bin2gray(
      input logic [`DHRX_FIFO_AW:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   // Link domain reset, released on the link clock
   logic lrst_a_q;
   logic lrst_q;
   always_ff @(posedge hs_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lrst_a_q <= 1'b1;
         lrst_q <= 1'b1;
      end
      else
      begin
         lrst_a_q <= 1'b0;
         lrst_q <= lrst_a_q;
      end
   end

   // Dual edge capture
   logic [`DHRX_LANES-1:0] rise_q;
   logic [`DHRX_LANES-1:0] fall_q;
   logic burst_q;
   always_ff @(posedge hs_clk or posedge lrst_q)
   begin
      if (lrst_q)
      begin
         rise_q <= 4'h0;
         burst_q <= 1'b0;
      end
      else
      begin
         rise_q <= lane_data;
         burst_q <= hs_burst;
      end
   end

   always_ff @(negedge hs_clk or posedge lrst_q)
   begin
      if (lrst_q)
         fall_q <= 4'h0;
      else
         fall_q <= lane_data;
   end

   // Byte assembly, least significant bit first
   logic [`DHRX_BYTE_W-1:0] sh_q [`DHRX_LANES];
   logic [`DHRX_BYTE_W-1:0] sh_d [`DHRX_LANES];
   logic [1:0] pair_q;
   logic wr_req;
   logic [`DHRX_WORD_W-1:0] wr_word;
   genvar gl;
   generate
      for (gl = 0; gl < `DHRX_LANES; gl++)
      begin : g_lane
         assign sh_d[gl] = {fall_q[gl], rise_q[gl], sh_q[gl][7:2]};
         assign wr_word[gl*8 +: 8] = sh_d[gl];
         always_ff @(posedge hs_clk or posedge lrst_q)
         begin
            if (lrst_q)
               sh_q[gl] <= 8'h00;
            else if (burst_q)
               sh_q[gl] <= sh_d[gl];
         end
      end
   endgenerate

   assign wr_req = burst_q && (pair_q == `DHRX_PAIRS_PER_BYTE);

   always_ff @(posedge hs_clk or posedge lrst_q)
   begin
      if (lrst_q)
         pair_q <= 2'h0;
      else if (!burst_q)
         pair_q <= 2'h0;
      else
         pair_q <= pair_q + 2'h1;
   end

   // Elastic FIFO with gray pointers
   logic [`DHRX_WORD_W-1:0] mem_q [1 << `DHRX_FIFO_AW];
   logic [`DHRX_FIFO_AW:0] wbin_q;
   logic [`DHRX_FIFO_AW:0] wgray_q;
   logic [`DHRX_FIFO_AW:0] rbin_q;
   logic [`DHRX_FIFO_AW:0] rgray_q;
   logic [`DHRX_FIFO_AW:0] rg_s1_q;
   logic [`DHRX_FIFO_AW:0] rg_s2_q;
   logic [`DHRX_FIFO_AW:0] wg_s1_q;
   logic [`DHRX_FIFO_AW:0] wg_s2_q;
   logic [`DHRX_FIFO_AW:0] wbin_d;
   logic [`DHRX_FIFO_AW:0] rbin_d;
   logic full;
   logic empty;
   logic wr_en;
   logic rd_en;

   assign full = (wgray_q == {~rg_s2_q[2:1], rg_s2_q[0]});
   assign wr_en = wr_req && !full;
   assign wbin_d = wbin_q + 3'h1;

   always_ff @(posedge hs_clk or posedge lrst_q)
   begin
      if (lrst_q)
      begin
         wbin_q <= 3'h0;
         wgray_q <= 3'h0;
         rg_s1_q <= 3'h0;
         rg_s2_q <= 3'h0;
      end
      else
      begin
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
         if (wr_en)
         begin
            wbin_q <= wbin_d;
            wgray_q <= bin2gray(wbin_d);
         end
      end
   end

   always_ff @(posedge hs_clk)
   begin
      if (wr_en)
         mem_q[wbin_q[1:0]] <= wr_word;
   end

   assign empty = (rgray_q == wg_s2_q);
   assign rd_en = !empty;
   assign rbin_d = rbin_q + 3'h1;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rbin_q <= 3'h0;
         rgray_q <= 3'h0;
         wg_s1_q <= 3'h0;
         wg_s2_q <= 3'h0;
      end
      else
      begin
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
         if (rd_en)
         begin
            rbin_q <= rbin_d;
            rgray_q <= bin2gray(rbin_d);
         end
      end
   end

   // Vertical timing tracker
   dhrx_pkg::dhrx_vstate_t st_q;
   dhrx_pkg::dhrx_vstate_t st_d;
   logic [`DHRX_LINE_W-1:0] sync_q;
   logic [`DHRX_LINE_W-1:0] back_q;
   logic [`DHRX_LINE_W-1:0] act_q;
   logic [`DHRX_LINE_W-1:0] front_q;
   logic [`DHRX_LINE_W-1:0] start_sum;
   logic [`DHRX_LINE_W-1:0] blank_sum;
   logic [`DHRX_LINE_W-1:0] total_sum;
   logic head_ok;
   logic frame_good;
   logic frame_end;
   logic enter_active;

   assign start_sum = sync_q + back_q;
   assign blank_sum = start_sum + front_q;
   assign total_sum = blank_sum + act_q;
   assign head_ok = at_least(sync_q, `DHRX_MIN_SYNC)
      && at_least(back_q, `DHRX_MIN_BACK)
      && at_least(start_sum, `DHRX_MIN_START);
   assign frame_good = head_ok
      && at_least(front_q, `DHRX_MIN_FRONT)
      && at_least(blank_sum, `DHRX_MIN_BLANK)
      && (act_q == `DHRX_ACTIVE_LINES)
      && at_least(total_sum, `DHRX_MIN_TOTAL);
   assign frame_end = line_start && line_is_sync
      && (st_q != dhrx_pkg::VS_SYNC) && (st_q != dhrx_pkg::VS_IDLE);
   assign enter_active = line_start && line_is_active && !line_is_sync
      && (st_q == dhrx_pkg::VS_BACK || st_q == dhrx_pkg::VS_SYNC);

   always_comb
   begin
      st_d = st_q;
      if (line_start)
      begin
         case (st_q)
            dhrx_pkg::VS_IDLE:
               if (line_is_sync)
                  st_d = dhrx_pkg::VS_SYNC;
            dhrx_pkg::VS_SYNC, dhrx_pkg::VS_BACK:
               if (line_is_sync)
                  st_d = dhrx_pkg::VS_SYNC;
               else if (line_is_active)
                  st_d = dhrx_pkg::VS_ACTIVE;
               else
                  st_d = dhrx_pkg::VS_BACK;
            dhrx_pkg::VS_ACTIVE, dhrx_pkg::VS_FRONT:
               if (line_is_sync)
                  st_d = dhrx_pkg::VS_SYNC;
               else if (line_is_active)
                  st_d = dhrx_pkg::VS_ACTIVE;
               else
                  st_d = dhrx_pkg::VS_FRONT;
            default:
               st_d = dhrx_pkg::VS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= dhrx_pkg::VS_IDLE;
         sync_q <= 11'h000;
         back_q <= 11'h000;
         act_q <= 11'h000;
         front_q <= 11'h000;
      end
      else
      begin
         st_q <= st_d;
         if (line_start)
         begin
            if (line_is_sync && st_q != dhrx_pkg::VS_SYNC)
            begin
               sync_q <= 11'h001;
               back_q <= 11'h000;
               act_q <= 11'h000;
               front_q <= 11'h000;
            end
            else if (st_d == dhrx_pkg::VS_SYNC)
               sync_q <= sat_inc(sync_q);
            else if (st_d == dhrx_pkg::VS_BACK)
               back_q <= sat_inc(back_q);
            else if (st_d == dhrx_pkg::VS_ACTIVE)
               act_q <= sat_inc(act_q);
            else if (st_d == dhrx_pkg::VS_FRONT)
               front_q <= sat_inc(front_q);
         end
      end
   end

   // Output stage: pixel writes only in active lines after a well formed sync and back porch
   logic gate_q;
   logic px_valid_q;
   logic [`DHRX_WORD_W-1:0] px_data_q;
   logic frame_ok_q;
   logic frame_bad_q;
   logic px_allow;

   assign px_allow = gate_q && (st_q == dhrx_pkg::VS_ACTIVE)
      && (act_q <= `DHRX_ACTIVE_LINES);

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gate_q <= 1'b0;
         px_valid_q <= 1'b0;
         px_data_q <= 32'h0000_0000;
         frame_ok_q <= 1'b0;
         frame_bad_q <= 1'b0;
      end
      else
      begin
         if (enter_active)
            gate_q <= head_ok;
         else if (line_start && line_is_sync)
            gate_q <= 1'b0;
         px_valid_q <= rd_en && px_allow;
         if (rd_en)
            px_data_q <= mem_q[rbin_q[1:0]];
         frame_ok_q <= frame_end && frame_good;
         frame_bad_q <= frame_end && !frame_good;
      end
   end

   assign px_data = px_data_q;
   assign px_valid = px_valid_q;
   assign frame_ok = frame_ok_q;
   assign frame_bad = frame_bad_q;
   assign timing_gate = gate_q;

   // Checks
   sequence burst_begin_s;
      !burst_q ##1 burst_q;
   endsequence

   property first_pair_p;
      @(posedge hs_clk) disable iff (lrst_q)
      burst_begin_s |-> (pair_q == 2'h0);
   endproperty

   first_bit_a: assert property (first_pair_p)
      else $error("burst did not start on a rising edge pair");

   byte_span_a: assert property (@(posedge hs_clk) disable iff (lrst_q)
      wr_req |-> $past(burst_q, 3) && (pair_q == 2'h3))
      else $error("byte formed from fewer than four bit pairs");

   pair_step_a: assert property (@(posedge hs_clk) disable iff (lrst_q)
      burst_q && $past(burst_q) |-> pair_q == $past(pair_q) + 2'h1)
      else $error("bit pair not taken on every link clock cycle");

   no_overrun_a: assert property (@(posedge hs_clk) disable iff (lrst_q)
      wr_en |-> !full ##1 (wbin_q != $past(wbin_q)))
      else $error("elastic buffer written while full");

   frame_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      frame_ok_q |-> $past(act_q) == `DHRX_ACTIVE_LINES)
      else $error("frame accepted without full active line count");

   bad_frame_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      frame_end && ($past(st_q) != dhrx_pkg::VS_IDLE)
      && (sync_q < `DHRX_MIN_SYNC) |=> frame_bad_q && !frame_ok_q)
      else $error("short sync frame not flagged");

   pixel_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      px_valid_q |-> $past(gate_q) && $past(st_q) == dhrx_pkg::VS_ACTIVE)
      else $error("pixel written outside a valid active region");

endmodule
`default_nettype wire

// ---- rtl/dhrx_params.svh ----
// Constants for the serial video link receiver and vertical timing checker
`ifndef DHRX_PARAMS_SVH
`define DHRX_PARAMS_SVH
`define DHRX_LANES 4
`define DHRX_BYTE_W 8
`define DHRX_WORD_W 32
`define DHRX_PAIRS_PER_BYTE 2'h3
`define DHRX_FIFO_AW 2
`define DHRX_LINE_W 11
`define DHRX_MIN_SYNC 11'h002
`define DHRX_MIN_FRONT 11'h002
`define DHRX_MIN_BACK 11'h002
`define DHRX_MIN_START 11'h004
`define DHRX_MIN_BLANK 11'h006
`define DHRX_ACTIVE_LINES 11'h500
`define DHRX_MIN_TOTAL 11'h506
`endif

// ---- rtl/dhrx_pkg.sv ----
// Types for the serial video link receiver
package dhrx_pkg;
   typedef enum logic [2:0] {
      VS_IDLE,
      VS_SYNC,
      VS_BACK,
      VS_ACTIVE,
      VS_FRONT
   } dhrx_vstate_t;
endpackage

// ---- verif/dhrx_link_master.sv ----
// Link master model: forwarded DDR clock and four data lanes
`timescale 1ns/1ns
`default_nettype none
module dhrx_link_master
(
   // Forwarded clock and lanes
   output logic hs_clk,
   output logic hs_burst,
   output logic [3:0] lane_data
);
   initial
   begin
      hs_clk = 1'h0;
      hs_burst = 1'h0;
      lane_data = 4'h5;
   end
   // Clock pulses outside a burst, lanes toggling
   task automatic idle_clk(input int n);
      repeat (n)
      begin
         lane_data = ~lane_data;
         #32 hs_clk = 1'h1;
         #32 hs_clk = 1'h0;
      end
   endtask
   // One burst of words; sp shortens odd bits as a spread clock would
   task automatic send(input logic [31:0] w[$], input int sp);
      foreach (w[i])
         for (int b = 0; b < 8; b++)
         begin
            for (int l = 0; l < 4; l++)
               lane_data[l] = w[i][8*l+b];
            hs_burst = 1'h1;
            #(6 - sp * (b % 2)) hs_clk = ~hs_clk;
            #(6 - sp * (b % 2));
         end
      lane_data = ~lane_data;
      #6 hs_clk = 1'h1;
      #6 hs_clk = 1'h0;
      #6 hs_burst = 1'h0;
      idle_clk(1);
   endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the video link receiver
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys, sys_rst, hs_clk, hs_burst;
   logic line_start, line_is_sync, line_is_active;
   logic [3:0] lane_data;
   logic [31:0] px_data;
   logic px_valid, frame_ok, frame_bad, timing_gate;
   int n_fail = 0;
   int n_compared = 0;
   int n_ok = 0;
   int n_bad = 0;
   logic [31:0] got[$];
   initial clk_sys = 1'h0;
   always #10 clk_sys = ~clk_sys;
   dhrx_video_rx DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .hs_clk(hs_clk), .hs_burst(hs_burst), .lane_data(lane_data),
      .line_start(line_start), .line_is_sync(line_is_sync),
      .line_is_active(line_is_active), .px_data(px_data),
      .px_valid(px_valid), .frame_ok(frame_ok), .frame_bad(frame_bad),
      .timing_gate(timing_gate));
   dhrx_link_master partner (.hs_clk(hs_clk), .hs_burst(hs_burst),
      .lane_data(lane_data));
   always @(negedge clk_sys)
   begin
      if (px_valid === 1'h1) got.push_back(px_data);
      if (frame_ok === 1'h1) n_ok++;
      if (frame_bad === 1'h1) n_bad++;
   end
   task automatic final_report;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic lines(input int n, input logic s, input logic a);
      repeat (n)
      begin
         @(negedge clk_sys);
         line_start = 1'h1;
         line_is_sync = s;
         line_is_active = a;
      end
      @(negedge clk_sys);
      line_start = 1'h0;
   endtask
   // Send a burst and compare the words that come out, or their absence
   task automatic burst(input logic [31:0] w[$], input int sp,
                        input logic shown);
      int k;
      k = 0;
      partner.send(w, sp);
      while (got.size() < w.size() && k < 300)
      begin
         @(posedge clk_sys);
         k++;
      end
      if (shown && k == 300)
      begin
         n_fail++;
         final_report;
      end
      chk(got.size(), shown ? w.size() : 0);
      foreach (got[i])
         chk(got[i], w[i]);
      got.delete();
   endtask
   task automatic wait_judge(input int ok, input int bad);
      repeat (4) @(negedge clk_sys);
      chk(n_ok, ok);
      chk(n_bad, bad);
      chk_flag(timing_gate, 1'h0);
   endtask
   task automatic t_good_frame;
      lines(2, 1'h1, 1'h0);
      lines(2, 1'h0, 1'h0);
      lines(1, 1'h0, 1'h1);
      chk_flag(timing_gate, 1'h1);
      burst('{32'ha5c3_0ff1, 32'h5a3c_f00e, 32'hffff_0000}, 0, 1'h1);
      burst('{32'h1357_9bdf, 32'h8000_0001, 32'h00ff_7e81}, 4, 1'h1);
      lines(1279, 1'h0, 1'h1);
      lines(2, 1'h0, 1'h0);
      lines(1, 1'h1, 1'h0);
      wait_judge(1, 0);
   endtask
   task automatic t_short_sync;
      lines(3, 1'h0, 1'h0);
      lines(1, 1'h0, 1'h1);
      chk_flag(timing_gate, 1'h0);
      burst('{32'h0123_4567}, 0, 1'h0);
      lines(1279, 1'h0, 1'h1);
      lines(2, 1'h0, 1'h0);
      lines(1, 1'h1, 1'h0);
      wait_judge(1, 1);
   endtask
   task automatic t_short_front;
      lines(1, 1'h1, 1'h0);
      lines(2, 1'h0, 1'h0);
      lines(1280, 1'h0, 1'h1);
      lines(1, 1'h0, 1'h0);
      lines(1, 1'h1, 1'h0);
      wait_judge(1, 2);
   endtask
   initial
   begin
      sys_rst = 1'h1;
      line_start = 1'h0;
      line_is_sync = 1'h0;
      line_is_active = 1'h0;
      fork
         partner.idle_clk(3);
         repeat (16) @(negedge clk_sys);
      join
      chk_flag(px_valid | frame_ok | frame_bad | timing_gate, 1'h0);
      sys_rst = 1'h0;
      partner.idle_clk(3);
      t_good_frame();
      t_short_sync();
      t_short_front();
      final_report;
   end
endmodule
`default_nettype wire
